// [kwi_keypad_wake.sv]
`timescale 1ns/1ps
// How it works
// [R1] Eight enable bits select keypad input pins.
// [R2] Enabled pin turns on its pull-up.
// [R3] Latch request when enabled pins fall from all-high.
// [R4] Edge mode: no latch while another pin low.
// [R5] Level mode: request holds while any pin low.
// [R6] Level mode: clear needs acknowledge and all high.
// [R7] Acknowledge from vector fetch or software write.
// [R8] Acknowledge does not disturb later edge detection.
// [R9] Unmasked request makes CPU take fixed vector.
// [R10] Edge mode: acknowledge clears request at once.
// [R11] Reset clears request and sensitivity select.
// [R12] Pending flag shows latch, ignores mask.
// [R13] Enable forces input; level read needs direction zero.
// [R14] Acknowledge bit is write-only, reads zero.
// [R15] Mask bit blocks request; reset clears it.
// [R16] Sensitivity: one edge plus level, zero edge.
// [R17] Status/control first address, pin enable second.
// [R18] Reset clears all pin enable bits.
// [R19] Works in wait and stop; wakes processor.
// [R20] Break clear enabled: break acknowledge clears latch.
// [R21] Break clear disabled: break acknowledge ignored.
// [R22] Software: mask, enable, acknowledge, then unmask.
// [R23] Software may preset pins as outputs high.
// [R24] Interrupt output is latch and not mask.
module kwi_keypad_wake (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] shared_port_pins_in,
  output logic [7:0] shared_port_pins_out,
  output logic [7:0] shared_port_pins_oe,
  output logic [7:0] pin_pullup_en,
  input wire logic vector_fetch,
  input wire logic break_state,
  input wire logic low_power_mode,
  output logic [15:0] irq_vector_addr,
  output logic irq_request,
  output logic wake_request
);
  logic [7:0] pin_irq_enable_bits;
  logic [7:0] port_data;
  logic [7:0] port_dir;
  logic request_mask;
  logic trigger_sensitivity_sel;
  logic break_clear_enable;
  logic [7:0] pin_sync;
  logic all_high_prev;
  logic ack_seen;
  kwi_pkg::kwi_state_t state;
  kwi_pkg::kwi_state_t next_state;
  logic access;
  logic wr;
  logic sw_ack;
  logic ack_any;
  logic all_high_now;
  logic fall_event;
  logic [7:0] pin_level;
  logic request_pending_flag;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    return a == target;
  endfunction

  kwi_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(shared_port_pins_in),
    .q(pin_sync)
  );

  assign access = psel && penable;
  assign wr = access && pwrite;
  // Break state only lets a software acknowledge through when break clear is on.
  assign sw_ack = wr && hit(paddr, kwi_pkg::ADDR_STATUS_CONTROL) && pwdata[kwi_pkg::BIT_ACK]
                  && (!break_state || break_clear_enable); // [R7] [R20] [R21]
  assign ack_any = sw_ack || vector_fetch; // [R7]
  // Disabled pins count as high so they never trigger or hold the request.
  assign all_high_now = &(pin_sync | ~pin_irq_enable_bits); // [R1]
  // A new request needs every enabled pin high in the previous cycle.
  assign fall_event = all_high_prev && !all_high_now; // [R3] [R4] [R8]
  assign request_pending_flag = (state != kwi_pkg::KWI_IDLE); // [R12]
  assign pin_level = pin_sync & ~port_dir; // [R13]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      all_high_prev <= 1'b1;
    end else begin
      all_high_prev <= all_high_now;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      kwi_pkg::KWI_IDLE: begin
        if (fall_event) begin
          next_state = kwi_pkg::KWI_LATCHED; // [R3]
        end
      end
      kwi_pkg::KWI_LATCHED: begin
        if (ack_any && !fall_event) begin
          if (trigger_sensitivity_sel && !all_high_now) begin
            next_state = kwi_pkg::KWI_HOLD; // [R5] [R6]
          end else begin
            next_state = kwi_pkg::KWI_IDLE; // [R10]
          end
        end
      end
      kwi_pkg::KWI_HOLD: begin
        if (fall_event) begin
          next_state = kwi_pkg::KWI_LATCHED; // [R8]
        end else if (!trigger_sensitivity_sel || all_high_now) begin
          next_state = kwi_pkg::KWI_IDLE; // [R6]
        end
      end
      default: begin
        next_state = kwi_pkg::KWI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= kwi_pkg::KWI_IDLE; // [R11]
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen <= 1'b0;
    end else begin
      ack_seen <= ack_any;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      request_mask <= 1'b0; // [R15]
      trigger_sensitivity_sel <= 1'b0; // [R11]
      pin_irq_enable_bits <= kwi_pkg::PIN_RESET; // [R18]
      break_clear_enable <= 1'b0; // [R21]
      port_data <= kwi_pkg::PIN_RESET;
      port_dir <= kwi_pkg::PIN_RESET;
    end else if (wr) begin
      if (hit(paddr, kwi_pkg::ADDR_STATUS_CONTROL)) begin // [R17]
        request_mask <= pwdata[kwi_pkg::BIT_MASK];
        trigger_sensitivity_sel <= pwdata[kwi_pkg::BIT_SENS]; // [R16]
      end
      if (hit(paddr, kwi_pkg::ADDR_PIN_ENABLE)) begin // [R17]
        pin_irq_enable_bits <= pwdata[7:0]; // [R1]
      end
      if (hit(paddr, kwi_pkg::ADDR_BREAK_CONTROL)) begin
        break_clear_enable <= pwdata[kwi_pkg::BIT_BREAK_CLEAR_ENABLE];
      end
      if (hit(paddr, kwi_pkg::ADDR_PORT_DATA)) begin
        port_data <= pwdata[7:0];
      end
      if (hit(paddr, kwi_pkg::ADDR_PORT_DIR)) begin
        port_dir <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shared_port_pins_out <= kwi_pkg::PIN_RESET;
      shared_port_pins_oe <= kwi_pkg::PIN_RESET;
      pin_pullup_en <= kwi_pkg::PIN_RESET;
    end else begin
      shared_port_pins_out <= port_data;
      shared_port_pins_oe <= port_dir & ~pin_irq_enable_bits; // [R13]
      pin_pullup_en <= pin_irq_enable_bits; // [R2]
    end
  end

  // The request stays live in wait and stop; the low-power input only gates the wake line.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      irq_vector_addr <= kwi_pkg::VECTOR_ADDR_HI;
    end else begin
      irq_request <= (next_state != kwi_pkg::KWI_IDLE) && !request_mask; // [R24] [R15] [R9]
      wake_request <= (next_state != kwi_pkg::KWI_IDLE) && !request_mask
                      && low_power_mode; // [R19]
      irq_vector_addr <= kwi_pkg::VECTOR_ADDR_HI; // [R9]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (hit(paddr, kwi_pkg::ADDR_STATUS_CONTROL)) begin
          prdata[kwi_pkg::BIT_PENDING] <= request_pending_flag; // [R12]
          prdata[kwi_pkg::BIT_ACK] <= 1'b0; // [R14]
          prdata[kwi_pkg::BIT_MASK] <= request_mask;
          prdata[kwi_pkg::BIT_SENS] <= trigger_sensitivity_sel;
        end else if (hit(paddr, kwi_pkg::ADDR_PIN_ENABLE)) begin
          prdata[7:0] <= pin_irq_enable_bits;
        end else if (hit(paddr, kwi_pkg::ADDR_BREAK_CONTROL)) begin
          prdata[kwi_pkg::BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable;
        end else if (hit(paddr, kwi_pkg::ADDR_PORT_DATA)) begin
          prdata[7:0] <= port_data;
        end else if (hit(paddr, kwi_pkg::ADDR_PORT_DIR)) begin
          prdata[7:0] <= port_dir;
        end else if (hit(paddr, kwi_pkg::ADDR_PIN_LEVEL)) begin
          prdata[7:0] <= pin_level; // [R13]
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// [kwi_keypad_wake_asserts.sv]
`timescale 1ns/1ps
module kwi_keypad_wake_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] shared_port_pins_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic low_power_mode,
  input wire logic [15:0] irq_vector_addr,
  input wire logic irq_request,
  input wire logic wake_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  answer_next_a: assert property (psel && !penable |=> pready) else $error("no answer");
  answer_once_a: assert property (pready |=> !pready) else $error("answer too long");
  unmapped_err_a: assert property (psel && !penable && (paddr < 12'h068 || paddr > 12'h07C)
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  ack_zero_a: assert property (pready && !pwrite && paddr == kwi_pkg::ADDR_STATUS_CONTROL
    |-> !prdata[kwi_pkg::BIT_ACK] && !pslverr) else $error("ack bit read one");
  enable_pullup_a: assert property (pready && pwrite && paddr == kwi_pkg::ADDR_PIN_ENABLE
    |-> ##2 pin_pullup_en == $past(pwdata[7:0], 2)) else $error("pull-up not enable");
  enable_input_a: assert property ($stable(pin_pullup_en)
    |-> (pin_pullup_en & shared_port_pins_oe) == 8'h00) else $error("enabled pin driven");
  vector_fixed_a: assert property (irq_vector_addr == kwi_pkg::VECTOR_ADDR_HI)
    else $error("vector moved");
  wake_irq_a: assert property (wake_request == (irq_request && $past(low_power_mode)))
    else $error("wake mismatch");
endmodule
bind kwi_keypad_wake kwi_keypad_wake_asserts i_chk (.mclk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .shared_port_pins_oe, .pin_pullup_en,
  .low_power_mode, .irq_vector_addr, .irq_request, .wake_request);

// [kwi_keys.sv]
`timescale 1ns/1ps
// A pressed key grounds its pin; a free pin follows the port driver, then the pull-up.
module kwi_keys (
  input wire logic mclk,
  input wire logic [7:0] press,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] shared_port_pins_out,
  input wire logic [7:0] shared_port_pins_oe,
  output logic [7:0] shared_port_pins_in
);
  // An undriven pin without pull-up toggles so no stale level is seen.
  logic [7:0] float_lvl = 8'h55;
  always @(posedge mclk) begin
    float_lvl <= ~float_lvl;
  end
  assign shared_port_pins_in = ~press & ((shared_port_pins_oe & shared_port_pins_out)
    | (~shared_port_pins_oe & (pin_pullup_en | float_lvl)));
endmodule

// [kwi_pkg.sv]
package kwi_pkg;
  localparam int unsigned REG_STATUS_CONTROL_IDX = 32'h0000001A;
  localparam int unsigned REG_PIN_ENABLE_IDX = 32'h0000001B;
  localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h068;
  localparam logic [11:0] ADDR_PIN_ENABLE = 12'h06C;
  localparam logic [11:0] ADDR_BREAK_CONTROL = 12'h070;
  localparam logic [11:0] ADDR_PORT_DATA = 12'h074;
  localparam logic [11:0] ADDR_PORT_DIR = 12'h078;
  localparam logic [11:0] ADDR_PIN_LEVEL = 12'h07C;
  localparam int unsigned BIT_PENDING = 3;
  localparam int unsigned BIT_ACK = 2;
  localparam int unsigned BIT_MASK = 1;
  localparam int unsigned BIT_SENS = 0;
  localparam int unsigned BIT_BREAK_CLEAR_ENABLE = 1;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [7:0] ALL_HIGH = 8'hFF;
  localparam logic [15:0] VECTOR_ADDR_HI = 16'hFFE0;
  localparam logic [15:0] VECTOR_ADDR_LO = 16'hFFE1;
  typedef enum logic [2:0] {
    KWI_IDLE = 3'b001,
    KWI_LATCHED = 3'b010,
    KWI_HOLD = 3'b100
  } kwi_state_t;
endpackage

// [kwi_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for the eight port pins.
module kwi_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= kwi_pkg::ALL_HIGH;
      q <= kwi_pkg::ALL_HIGH;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [test_keypad_wake_interrupt.sv]
`timescale 1ns/1ps
module test_keypad_wake_interrupt;
  typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e; logic x;} kwi_row_t;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic vector_fetch = 1'b0, break_state = 1'b0, low_power_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] press = 8'h00, shared_port_pins_in, shared_port_pins_out;
  logic [7:0] shared_port_pins_oe, pin_pullup_en;
  logic [15:0] irq_vector_addr;
  logic pready, pslverr, irq_request, wake_request, er;
  int err_total = 0, check_count = 0;
  kwi_row_t rows [6] = '{'{12'h068, 8'h07, 8'h03, 1'b0}, '{12'h06C, 8'hA5, 8'hA5, 1'b0},
    '{12'h070, 8'h02, 8'h02, 1'b0}, '{12'h074, 8'h3C, 8'h3C, 1'b0},
    '{12'h078, 8'h0F, 8'h0F, 1'b0}, '{12'h060, 8'hFF, 8'h00, 1'b1}};
  kwi_keypad_wake i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .shared_port_pins_in, .shared_port_pins_out, .shared_port_pins_oe,
    .pin_pullup_en, .vector_fetch, .break_state, .low_power_mode, .irq_vector_addr,
    .irq_request, .wake_request);
  kwi_keys i_keys (.mclk, .press, .pin_pullup_en, .shared_port_pins_out,
    .shared_port_pins_oe, .shared_port_pins_in);
  always #2.5 mclk = ~mclk;
  task automatic cmp(input string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpb(input string nm, logic e, logic g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic [11:0] a, logic w, logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic key(input logic [7:0] k);
    press <= k;
    repeat (5) @(posedge mclk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    results();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      apb(rows[i].a, 1'b0, 32'h0);
      cmp("reset", 32'h0, rd);
    end
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, {24'h0, rows[i].w});
      apb(rows[i].a, 1'b0, 32'h0);
      cmp("readback", {24'h0, rows[i].e}, rd);
      cmpb("slverr", rows[i].x, er);
    end
    cmp("oe", 32'h0A, {24'h0, shared_port_pins_oe});
    apb(12'h06C, 1'b1, 32'h03);
    apb(12'h068, 1'b1, 32'h06);
    apb(12'h068, 1'b1, 32'h00);
    key(8'h01);
    cmpb("irq", 1'b1, irq_request);
    apb(12'h068, 1'b0, 32'h0);
    cmp("pending", 32'h08, rd);
    apb(12'h068, 1'b1, 32'h04);
    key(8'h03);
    cmpb("irq", 1'b0, irq_request);
    key(8'h00);
    key(8'h02);
    cmpb("irq", 1'b1, irq_request);
    vector_fetch <= 1'b1;
    @(posedge mclk);
    vector_fetch <= 1'b0;
    key(8'h00);
    cmpb("irq", 1'b0, irq_request);
    apb(12'h068, 1'b1, 32'h02);
    key(8'h01);
    cmpb("irq", 1'b0, irq_request);
    apb(12'h068, 1'b0, 32'h0);
    cmp("pending", 32'h0A, rd);
    apb(12'h068, 1'b1, 32'h06);
    key(8'h00);
    apb(12'h068, 1'b1, 32'h01);
    low_power_mode <= 1'b1;
    key(8'h01);
    cmpb("wake", 1'b1, wake_request);
    apb(12'h068, 1'b1, 32'h05);
    key(8'h01);
    cmpb("irq", 1'b1, irq_request);
    key(8'h00);
    cmpb("irq", 1'b0, irq_request);
    low_power_mode <= 1'b0;
    apb(12'h070, 1'b1, 32'h00);
    apb(12'h068, 1'b1, 32'h00);
    break_state <= 1'b1;
    key(8'h01);
    apb(12'h068, 1'b1, 32'h04);
    key(8'h01);
    cmpb("irq", 1'b1, irq_request);
    apb(12'h070, 1'b1, 32'h02);
    apb(12'h068, 1'b1, 32'h04);
    break_state <= 1'b0;
    key(8'h01);
    cmpb("irq", 1'b0, irq_request);
    apb(12'h068, 1'b1, 32'h01);
    key(8'h01);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(12'h068, 1'b0, 32'h0);
    cmp("status", 32'h0, rd);
    cmpb("irq", 1'b0, irq_request);
    apb(12'h074, 1'b1, 32'h04);
    apb(12'h078, 1'b1, 32'h04);
    apb(12'h06C, 1'b1, 32'h04);
    key(8'h01);
    cmpb("irq", 1'b0, irq_request);
    cmp("port out", 32'h04, {24'h0, shared_port_pins_out});
    results();
  end
endmodule
